// ### core_issue_model.sv
// Integer core model issuing one register transfer per call.
// Assumes the block samples requests on the rising clock edge.
`timescale 1ns/1ps
module core_issue_model (
    input  wire logic   clk_sys,
    output logic        xferValid,
    output logic        otherForm,
    output logic        privMode,
    output logic [31:0] instrWord,
    output logic [31:0] writeData
);
    sysctl_coproc_pkg::xfer_instr_type ins;
    initial begin
        {xferValid, otherForm, privMode, instrWord, writeData} = 67'h0;
    end
    task issue(input logic oth, input logic priv, input logic rd, input logic [3:0] prim, input logic [2:0] op2);
        @(posedge clk_sys);
        #1;
        ins = '{4'hE, 4'hE, 3'h0, rd, prim, 4'h1, 4'hF, op2, 1'h1, 4'h0};
        {instrWord, otherForm, privMode, writeData} = {ins, oth, priv, 32'h0};
        xferValid = 1'b1;
        @(posedge clk_sys);
        #1;
        xferValid = 1'b0;
        // Released lines show a changed pattern, not the last value
        {instrWord, writeData} = ~{instrWord, writeData};
    endtask
endmodule

// ### sysctl_coproc_id_regs.sv
// Identification register group of the system control coprocessor.
// Answers each presented transfer with a registered pulse one clock later.
// Writes are taken and dropped: every register here is read only.
// Assumes the core drives instruction, strobe and privilege on clk_sys.
//
// Summary of operation
// - Accept transfers only as register-transfer instructions in privileged mode.
// - Decode the instruction into condition, opcodes, direction bit 20, register numbers.
// - Trapping accesses raise the undefined-instruction exception instead of transfer.
// - Any data written or read anywhere causes no harm.
// - Primary 0 read: opcode2 1 cache type, 2 TCM status, else identification.
// - Identification is fixed: implementer, variant, architecture, part, revision.
// - Cache type: top three zero, class, split flag, data and instruction geometry.
// - Split flag is 1 for separate caches; this device reports 1.
// - A unified report would make both geometry fields identical.
// - Class code 1110 means write-back, register 7 cleaning, lockdown format C.
// - Geometry: two zero bits, size, associativity, multiplier, line length.
// - Size code 0011 is 4KB, doubling per step up to 1000 for 128KB.
// - Associativity reads 010 for 4-way; line length reads 10 for 32 bytes.

`timescale 1ns/1ps
module sysctl_coproc_id_regs #(
    parameter logic [7:0]  IMPLEMENTER = 8'h5A,  // Arbitrary value
    parameter logic [3:0]  VARIANT     = 4'h1,   // Arbitrary value
    parameter logic [3:0]  ARCH        = 4'h2,   // Arbitrary value
    parameter logic [11:0] PART_NUM    = 12'hABC, // Arbitrary value
    parameter logic [3:0]  REVISION    = 4'h3,   // Arbitrary value
    parameter int          ICACHE_KB   = 16,
    parameter int          DCACHE_KB   = 8,
    parameter logic [31:0] TCM_STATUS  = 32'h0000_0000
) (
    input  wire logic        clk_sys,
    input  wire logic        rst_n,
    input  wire logic        xferValid,
    input  wire logic        otherForm,
    input  wire logic        privMode,
    input  wire logic [31:0] instrWord,
    input  wire logic [31:0] writeData,
    output logic             xferDone,
    output logic             undefTrap,
    output logic [31:0]      readData
);

    // Smallest cache size and number of sizes from it up to the largest
    localparam int MIN_CACHE_KB = 4;
    localparam int SIZE_STEPS   = 6;
    localparam int N_CACHES     = 2;
    // Data cache first, instruction cache second
    localparam int CACHE_KB [N_CACHES] = '{DCACHE_KB, ICACHE_KB};

    // Decoded instruction and register contents
    sysctl_coproc_pkg::xfer_instr_type instr;
    sysctl_coproc_pkg::read_sel_type   sel;
    sysctl_coproc_pkg::cache_info_type cacheInfo;
    sysctl_coproc_pkg::id_code_type    idCode;
    sysctl_coproc_pkg::geometry_type   geomArr [N_CACHES];
    logic                              isRead;
    logic                              idRead;
    logic [31:0]                       selData;

    // Answer state
    logic                              trap;
    logic                              accept;
    logic                              xferDone_ff;
    logic                              nxt_xferDone;
    logic                              undefTrap_ff;
    logic                              nxt_undefTrap;

    // Read data state
    logic [31:0]                       readData_ff;
    logic [31:0]                       nxt_readData;
    logic                              unusedBits;

    // Size code from cache size in KB; out-of-range sizes clamp to the ends
    // Non-powers of two round down to the next smaller code
    function automatic logic [3:0] sizeCode(input int kb);
        logic [3:0] code;
        code = sysctl_coproc_pkg::SIZE_4KB_CODE;
        // Last step whose size fits decides the code
        for (int i = 0; i < SIZE_STEPS; i++) begin
            if (kb >= (MIN_CACHE_KB << i)) begin
                code = 4'(int'(sysctl_coproc_pkg::SIZE_4KB_CODE) + i);
            end
        end
        return code;
    endfunction

    // Multiplier stays 0 because both caches are present
    function automatic sysctl_coproc_pkg::geometry_type geom(input int kb);
        sysctl_coproc_pkg::geometry_type g;
        g.zeroBits = 2'h0;
        g.size     = sizeCode(kb);
        g.assoc    = sysctl_coproc_pkg::ASSOC_4WAY;
        g.mult     = sysctl_coproc_pkg::MULT_ZERO;
        g.lineLen  = sysctl_coproc_pkg::LINE_8WORD;
        return g;
    endfunction

    assign instr  = instrWord;
    assign isRead = instrWord[sysctl_coproc_pkg::DIR_POS];
    // Only primary register 0 holds readable contents here
    assign idRead = isRead && (instr.primaryReg == sysctl_coproc_pkg::PRIMARY_ID);

    // Both geometry fields share one layout, built once per cache
    for (genvar c = 0; c < N_CACHES; c++) begin : g_geom
        assign geomArr[c] = geom(CACHE_KB[c]);
    end

    // Fixed identification word; every field is a build parameter
    always_comb begin
        idCode.implementer = IMPLEMENTER;
        idCode.variant     = VARIANT;
        idCode.arch        = ARCH;
        idCode.partNum     = PART_NUM;
        idCode.revision    = REVISION;
    end

    // Cache type word; the split flag is fixed for this device
    always_comb begin
        cacheInfo.zeroBits   = 3'h0;
        cacheInfo.cacheClass = sysctl_coproc_pkg::CACHE_CLASS_WB;
        cacheInfo.split      = sysctl_coproc_pkg::SPLIT_CACHE;
        cacheInfo.dGeom      = geomArr[0];
        // Unified report would reuse the data geometry
        if (sysctl_coproc_pkg::SPLIT_CACHE) begin
            cacheInfo.iGeom = geomArr[1];
        end else begin
            cacheInfo.iGeom = geomArr[0];
        end
    end

    // Codes 0 and 3 to 7 all select the identification word
    always_comb begin
        unique case (instr.opc2)
            sysctl_coproc_pkg::SEL_CACHE_TYPE: begin
                sel = sysctl_coproc_pkg::SEL_CACHE;
            end
            sysctl_coproc_pkg::SEL_TCM_STATUS: begin
                sel = sysctl_coproc_pkg::SEL_TCM;
            end
            default: begin
                sel = sysctl_coproc_pkg::SEL_ID;
            end
        endcase
    end

    // Register word for the selected code
    always_comb begin
        unique case (sel)
            sysctl_coproc_pkg::SEL_CACHE: begin
                selData = cacheInfo;
            end
            sysctl_coproc_pkg::SEL_TCM: begin
                selData = TCM_STATUS;
            end
            default: begin
                // The fourth selector code cannot arise
                selData = idCode;
            end
        endcase
    end

    // Other instruction forms or unprivileged transfers trap
    // A trap answers in place of done, so the core never sees both
    assign trap   = xferValid && (otherForm || !privMode);
    assign accept = xferValid && !trap;

    // Registered so the answer lands exactly one edge after the request
    always_comb begin
        nxt_xferDone  = accept;
        nxt_undefTrap = trap;
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            xferDone_ff  <= 1'b0;
            undefTrap_ff <= 1'b0;
        end else begin
            xferDone_ff  <= nxt_xferDone;
            undefTrap_ff <= nxt_undefTrap;
        end
    end

    // Trapped transfers and writes leave the last read value standing
    // Reads of other primary registers are absorbed and return zero
    always_comb begin
        nxt_readData = readData_ff;
        if (accept && idRead) begin
            nxt_readData = selData;
        end else if (accept && isRead) begin
            nxt_readData = sysctl_coproc_pkg::RESET_DATA;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            readData_ff <= sysctl_coproc_pkg::RESET_DATA;
        end else begin
            readData_ff <= nxt_readData;
        end
    end

    // Outputs come straight from the registers
    assign readData  = readData_ff;
    assign xferDone  = xferDone_ff;
    assign undefTrap = undefTrap_ff;

    // Fields the block decodes but never acts on
    assign unusedBits = ^{writeData,
                          instr.cond,
                          instr.fixedA,
                          instr.opc1,
                          instr.coreReg,
                          instr.fixedB,
                          instr.fixedC,
                          instr.secondaryReg};

endmodule

// ### sysctl_coproc_id_regs_properties.sv
// Port checks of the identification register block.
// Assumes the block's default identification parameters.
`timescale 1ns/1ps
module sysctl_coproc_id_regs_checker #(
    parameter logic [31:0] ID_VALUE = 32'h5A12ABC3  // Arbitrary value
) (
    input wire logic        clk_sys,
    input wire logic        rst_n,
    input wire logic        xferValid,
    input wire logic        otherForm,
    input wire logic        privMode,
    input wire logic [31:0] instrWord,
    input wire logic [31:0] writeData,
    input wire logic        xferDone,
    input wire logic        undefTrap,
    input wire logic [31:0] readData
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    sequence taken;
        xferValid && privMode && !otherForm;
    endsequence
    sequence readSel(logic [2:0] sel);
        taken ##0 instrWord[20] && instrWord[19:16] == 4'h0 && instrWord[7:5] == sel;
    endsequence
    sequence idSel;
        taken ##0 instrWord[20] && instrWord[19:16] == 4'h0 && !(instrWord[7:5] inside {3'h1, 3'h2});
    endsequence
    a_accept_gives_done: assert property (taken |=> xferDone && !undefTrap)
        else $error("accepted transfer not answered by done");
    a_refuse_gives_trap: assert property (xferValid && (!privMode || otherForm) |=> undefTrap && !xferDone)
        else $error("refused transfer not trapped");
    a_idle_no_answer: assert property (!xferValid |=> !xferDone && !undefTrap)
        else $error("answer without request");
    a_data_holds: assert property (!(xferValid && privMode && !otherForm && instrWord[20]) |=> $stable(readData))
        else $error("read data changed without accepted read");
    a_id_all_selects: assert property (idSel |=> readData == ID_VALUE)
        else $error("identification value wrong");
    a_cache_class_split: assert property (readSel(3'h1) |=> readData[31:24] == 8'h1D)
        else $error("cache class or split flag wrong");
    a_cache_geom_fields: assert property (readSel(3'h1) |=> readData[23:22] == 2'h0 && readData[17:12] == 6'h12
        && readData[11:10] == 2'h0 && readData[5:0] == 6'h12)
        else $error("cache geometry fields wrong");
    a_tcm_status_value: assert property (readSel(3'h2) |=> readData == 32'h0)
        else $error("tightly coupled memory status wrong");
endmodule
bind sysctl_coproc_id_regs sysctl_coproc_id_regs_checker u_checker (.clk_sys(clk_sys), .rst_n(rst_n),
    .xferValid(xferValid), .otherForm(otherForm), .privMode(privMode), .instrWord(instrWord),
    .writeData(writeData), .xferDone(xferDone), .undefTrap(undefTrap), .readData(readData));

// ### sysctl_coproc_pkg.sv
// Package for the system control coprocessor identification register block.
// Assumes the core presents one decoded transfer instruction at a time.
package sysctl_coproc_pkg;

    localparam int          DIR_POS        = 20;
    localparam logic [3:0]  PRIMARY_ID     = 4'h0;
    localparam logic [2:0]  SEL_CACHE_TYPE = 3'h1;
    localparam logic [2:0]  SEL_TCM_STATUS = 3'h2;

    localparam logic [3:0]  CACHE_CLASS_WB = 4'hE;
    localparam logic        SPLIT_CACHE    = 1'h1;
    localparam logic [2:0]  ASSOC_4WAY     = 3'h2;
    localparam logic [1:0]  LINE_8WORD     = 2'h2;
    localparam logic        MULT_ZERO      = 1'h0;
    localparam logic [3:0]  SIZE_4KB_CODE  = 4'h3;
    localparam logic [31:0] RESET_DATA     = 32'h0000_0000;

    typedef struct packed {
        logic [3:0]  cond;
        logic [3:0]  fixedA;
        logic [2:0]  opc1;
        logic        toCore;
        logic [3:0]  primaryReg;
        logic [3:0]  coreReg;
        logic [3:0]  fixedB;
        logic [2:0]  opc2;
        logic        fixedC;
        logic [3:0]  secondaryReg;
    } xfer_instr_type;

    typedef struct packed {
        logic [1:0]  zeroBits;
        logic [3:0]  size;
        logic [2:0]  assoc;
        logic        mult;
        logic [1:0]  lineLen;
    } geometry_type;

    typedef struct packed {
        logic [2:0]   zeroBits;
        logic [3:0]   cacheClass;
        logic         split;
        geometry_type dGeom;
        geometry_type iGeom;
    } cache_info_type;

    typedef struct packed {
        logic [7:0]  implementer;
        logic [3:0]  variant;
        logic [3:0]  arch;
        logic [11:0] partNum;
        logic [3:0]  revision;
    } id_code_type;

    typedef enum logic [1:0] {
        SEL_ID    = 2'b00,
        SEL_CACHE = 2'b01,
        SEL_TCM   = 2'b10
    } read_sel_type;

endpackage

// ### test_sysctl_coproc_id_regs.sv
// Self-checking bench of the identification register block.
// Assumes the block's default parameters and the core model.
`timescale 1ns/1ps
module test_sysctl_coproc_id_regs;
    localparam logic [31:0] ID_EXP = 32'h5A12ABC3;  // Arbitrary value
    localparam logic [31:0] CACHE_EXP = {3'h0, 4'hE, 1'h1, 2'h0, 4'h4, 3'h2, 1'h0, 2'h2, 2'h0, 4'h5, 3'h2, 1'h0, 2'h2};
    logic        clk_sys, rst_n, xferValid, otherForm, privMode, xferDone, undefTrap;
    logic [31:0] instrWord, writeData, readData;
    int          n_mismatch = 0, samples_checked = 0, cycles = 0;
    core_issue_model u_core (.clk_sys(clk_sys), .xferValid(xferValid), .otherForm(otherForm),
        .privMode(privMode), .instrWord(instrWord), .writeData(writeData));
    sysctl_coproc_id_regs u_dut (.clk_sys(clk_sys), .rst_n(rst_n), .xferValid(xferValid), .otherForm(otherForm),
        .privMode(privMode), .instrWord(instrWord), .writeData(writeData), .xferDone(xferDone),
        .undefTrap(undefTrap), .readData(readData));
    task check(input logic [33:0] seen, input logic [33:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task finish_test;
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // Expected value holds done, trap and read data
    task xfer(input logic oth, priv, rd, input logic [3:0] prim, input logic [2:0] op2, input logic [33:0] exp);
        u_core.issue(oth, priv, rd, prim, op2);
        check({xferDone, undefTrap, readData}, exp);
    endtask
    initial begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles > 2000) begin
            n_mismatch++;
            finish_test;
        end
    end
    initial begin
        rst_n = 1'b0;
        repeat (8) @(posedge clk_sys);
        #1;
        rst_n = 1'b1;
        check({xferDone, undefTrap, readData}, 34'h0);
        for (int i = 0; i < 8; i++) begin
            xfer(0, 1, 1, 4'h0, i[2:0], {2'b10, (i == 1) ? CACHE_EXP : (i == 2) ? 32'h0 : ID_EXP});
        end
        xfer(0, 0, 1, 4'h0, 3'h1, {2'b01, ID_EXP});
        xfer(1, 1, 1, 4'h0, 3'h1, {2'b01, ID_EXP});
        xfer(0, 1, 0, 4'h0, 3'h1, {2'b10, ID_EXP});
        xfer(0, 1, 1, 4'h3, 3'h0, {2'b10, 32'h0});
        xfer(0, 1, 1, 4'h0, 3'h1, {2'b10, CACHE_EXP});
        @(posedge clk_sys);
        #1;
        rst_n = 1'b0;
        @(posedge clk_sys);
        #1;
        rst_n = 1'b1;
        check({xferDone, undefTrap, readData}, 34'h0);
        xfer(0, 1, 1, 4'h0, 3'h5, {2'b10, ID_EXP});
        finish_test;
    end
endmodule
